// ===== uart_interrupt_mask_bench.sv
`timescale 1ns/1ps
module uart_interrupt_mask_bench;
  // Stimulus and observed outputs
  logic core_clk = 1'b0, nrst = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0, reg_rdata;
  logic [6:0] raw_irq = 7'h00, masked_irq, seen;
  logic uart_irq, event_irq;
  int fail_count = 0, cmp_count = 0, cyc = 0;
  // Rows: mask write, raw sources, expected requests
  logic [45:0] rows [7] = '{{32'h400, 7'h7f, 7'h40},
    {32'h200, 7'h7f, 7'h20}, {32'h100, 7'h7f, 7'h10},
    {32'h0c0, 7'h7f, 7'h0c}, {32'h030, 7'h7f, 7'h03},
    {32'h7f0, 7'h00, 7'h00}, {32'hffffffff, 7'h55, 7'h55}};
  uimsk_top DUT (.core_clk, .nrst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .raw_irq, .masked_irq, .uart_irq, .event_irq);
  uimsk_ctrl_model PEER (.core_clk, .nrst, .masked_irq, .uart_irq, .seen);
  initial forever #5 core_clk = ~core_clk;
  // Hang guard, far above the hundred or so cycles the run needs
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 2000) begin
      fail_count++;
      tally_and_finish();
    end
  end
  task automatic tally_and_finish();
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : tally_and_finish
  task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : cmp_word
  // One-cycle write strobe
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask : wr
  // One-cycle read; data valid only in the following cycle
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 cmp_word(reg_rdata, e);
  endtask : rd_chk
  // Settle time after a mask or source change
  task automatic settle(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : settle
  initial begin
    repeat (20) @(posedge core_clk);
    nrst <= 1'b1;
    rd_chk(8'h38, 32'h0);
    foreach (rows[i]) begin
      wr(8'h38, rows[i][45:14]);
      raw_irq <= rows[i][13:7];
      settle(3);
      cmp_word({25'h0, masked_irq}, {25'h0, rows[i][6:0]});
      cmp_word({25'h0, seen}, {25'h0, rows[i][6:0]});
      cmp_word({31'h0, uart_irq}, {31'h0, |rows[i][6:0]});
      rd_chk(8'h38, rows[i][45:14] & 32'h7f0);
    end
    // Reset in mid-run with every mask set
    @(posedge core_clk);
    nrst <= 1'b0;
    @(posedge core_clk);
    nrst <= 1'b1;
    #1 cmp_word({25'h0, masked_irq}, 32'h0);
    rd_chk(8'h38, 32'h0);
    wr(8'h80, 32'hffffffff);
    rd_chk(8'h80, 32'h0);
    // Sticky event: raise, mask, unmask, clear with source held high
    wr(8'h38, 32'h10);
    wr(8'h48, 32'h10);
    raw_irq <= 7'h01;
    settle(4);
    cmp_word({31'h0, event_irq}, 32'h1);
    wr(8'h48, 32'h0);
    settle(2);
    cmp_word({31'h0, event_irq}, 32'h0);
    wr(8'h48, 32'h10);
    wr(8'h44, 32'h10);
    settle(2);
    cmp_word({31'h0, event_irq}, 32'h0);
    wr(8'h38, 32'h20);
    rd_chk(8'h38, 32'h20);
    tally_and_finish();
  end
endmodule : uart_interrupt_mask_bench

// ===== uimsk_ctrl_model.sv
`timescale 1ns/1ps
// Interrupt controller stand-in: latches the request levels it is offered
module uimsk_ctrl_model (
  // Clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // Requests from the mask block
  input wire logic [6:0] masked_irq,
  input wire logic uart_irq,
  // Sources seen pending one cycle later
  output logic [6:0] seen
);
  // Only takes sources while the combined line is up, so both must agree
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      seen <= 7'h00;
    end else begin
      seen <= uart_irq ? masked_irq : 7'h00;
    end
  end
endmodule : uimsk_ctrl_model

// ===== uimsk_gate.sv
`timescale 1ns/1ps
// Per-source AND gate of raw interrupt against its mask bit
module uimsk_gate (
  // Mask and source bundle
  uimsk_gate_if.gate gif
);
  // One gate per source, kept combinational so masking is immediate
  for (genvar i = 0; i < uimsk_pkg::UIMSK_SRC_COUNT; i++) begin : g_src
    assign gif.gated[i] = gif.raw[i] & gif.mask[i]; // [RULE1]
  end
endmodule : uimsk_gate

// ===== uimsk_gate_if.sv
`timescale 1ns/1ps
// Carries mask, raw sources and gated result between top and gate
interface uimsk_gate_if;
  logic [6:0] mask;
  logic [6:0] raw;
  logic [6:0] gated;
  modport top (output mask, output raw, input gated);
  modport gate (input mask, input raw, output gated);
endinterface : uimsk_gate_if

// ===== uimsk_pkg.sv
package uimsk_pkg;
  // Register byte offsets on the plain register port
  localparam logic [7:0] UIMSK_ENABLE_MASK_OFS = 8'h38;
  localparam logic [7:0] UIMSK_RAW_STATUS_OFS = 8'h3c;
  localparam logic [7:0] UIMSK_MASKED_STATUS_OFS = 8'h40;
  localparam logic [7:0] UIMSK_EVENT_STATUS_OFS = 8'h44;
  localparam logic [7:0] UIMSK_EVENT_MASK_OFS = 8'h48;
  // Field positions within the mask register
  localparam int UIMSK_RECEIVE_BIT = 4;
  localparam int UIMSK_OVERRUN_BIT = 10;
  localparam int UIMSK_SRC_COUNT = 7;
  // Reset values
  localparam logic [6:0] UIMSK_MASK_RESET = 7'h00;
  localparam logic [31:0] UIMSK_RSVD_VALUE = 32'h0000_0000;
endpackage : uimsk_pkg

// ===== uimsk_top.sv
// Design decisions made here: strobed register access and the placing of the registers.
`timescale 1ns/1ps
// How it works
// [RULE1] Mask one passes raw interrupt, zero blocks
// [RULE2] Bit 10 overrun mask, reset zero, readable
// [RULE3] Bit 9 break mask, reset zero, readable
// [RULE4] Bit 8 parity mask, reset zero, readable
// [RULE5] Bits 7,6 framing, timeout masks, reset zero
// [RULE6] Bit 5 transmit mask, reset zero, readable
// [RULE7] Bit 4 receive mask, reset zero, readable
// [RULE8] Bits 3:0 reserved, read zero always
module uimsk_top (
  // Clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // Raw sources: bit 6 overrun .. bit 0 receive
  input wire logic [6:0] raw_irq,
  // Masked requests to the interrupt controller
  output logic [6:0] masked_irq,
  output logic uart_irq,
  // Level interrupt of the sticky event register
  output logic event_irq
);
  // All state in one struct
  typedef struct packed {
    logic [6:0] mask;
    logic [6:0] masked;
    logic uart_irq;
    logic [6:0] evt;
    logic [6:0] evt_mask;
    logic evt_irq;
    logic [31:0] rdata;
  } uimsk_state_t;

  uimsk_state_t st_reg;
  uimsk_state_t st_next;
  uimsk_gate_if gif ();

  // Gate sees the live mask so the output reg is one cycle behind
  assign gif.mask = st_reg.mask;
  assign gif.raw = raw_irq;
  uimsk_gate u_gate (.gif(gif));

  // Next-state logic: writes, sticky events, read mux
  always_comb begin
    logic [6:0] rise;
    rise = gif.gated & ~st_reg.masked;
    st_next = st_reg;
    // Mask register write; bits 3:0 and 31:11 are dropped
    if (reg_wr && reg_addr == uimsk_pkg::UIMSK_ENABLE_MASK_OFS) begin
      st_next.mask = reg_wdata[uimsk_pkg::UIMSK_OVERRUN_BIT:
                               uimsk_pkg::UIMSK_RECEIVE_BIT]; // [RULE2] [RULE3] [RULE4] [RULE5] [RULE6] [RULE7]
    end
    if (reg_wr && reg_addr == uimsk_pkg::UIMSK_EVENT_MASK_OFS) begin
      st_next.evt_mask = reg_wdata[10:4];
    end
    // Write one clears; a new rising request wins over the clear
    if (reg_wr && reg_addr == uimsk_pkg::UIMSK_EVENT_STATUS_OFS) begin
      st_next.evt = st_reg.evt & ~reg_wdata[10:4];
    end
    st_next.evt = st_next.evt | rise;
    st_next.masked = gif.gated; // [RULE1]
    st_next.uart_irq = |gif.gated;
    st_next.evt_irq = |(st_next.evt & st_next.evt_mask);
    // Read data stand one cycle after the strobe, else zero
    st_next.rdata = uimsk_pkg::UIMSK_RSVD_VALUE;
    if (reg_rd) begin
      unique case (reg_addr)
        uimsk_pkg::UIMSK_ENABLE_MASK_OFS:
          st_next.rdata = {21'h0, st_reg.mask, 4'h0}; // [RULE8]
        uimsk_pkg::UIMSK_RAW_STATUS_OFS:
          st_next.rdata = {21'h0, raw_irq, 4'h0};
        uimsk_pkg::UIMSK_MASKED_STATUS_OFS:
          st_next.rdata = {21'h0, gif.gated, 4'h0};
        uimsk_pkg::UIMSK_EVENT_STATUS_OFS:
          st_next.rdata = {21'h0, st_reg.evt, 4'h0};
        uimsk_pkg::UIMSK_EVENT_MASK_OFS:
          st_next.rdata = {21'h0, st_reg.evt_mask, 4'h0};
        default:
          st_next.rdata = uimsk_pkg::UIMSK_RSVD_VALUE;
      endcase
    end
  end

  // State register with synchronous reset
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      st_reg <= '0; // [RULE2] [RULE5]
    end else begin
      st_reg <= st_next;
    end
  end

  // Outputs straight from flops
  assign reg_rdata = st_reg.rdata;
  assign masked_irq = st_reg.masked;
  assign uart_irq = st_reg.uart_irq;
  assign event_irq = st_reg.evt_irq;

  // Checks
  sequence s_mask_write(int b);
    reg_wr && reg_addr == uimsk_pkg::UIMSK_ENABLE_MASK_OFS && reg_wdata[b];
  endsequence

  // The guard keeps the cycle right after a reset from comparing against
  // sources and masks that were seen before the reset wiped the mask
  a_gate_pass: assert property (@(posedge core_clk) disable iff (!nrst)
    $past(nrst) |-> masked_irq == $past(raw_irq & st_reg.mask)) // [RULE1]
    else $error("masked output differs from raw and mask");
  a_overrun_mask: assert property (@(posedge core_clk) disable iff (!nrst)
    s_mask_write(10) |=> st_reg.mask[6]) // [RULE2]
    else $error("overrun mask not stored");
  a_break_mask: assert property (@(posedge core_clk) disable iff (!nrst)
    s_mask_write(9) |=> st_reg.mask[5]) // [RULE3]
    else $error("break mask not stored");
  a_parity_mask: assert property (@(posedge core_clk) disable iff (!nrst)
    s_mask_write(8) |=> st_reg.mask[4]) // [RULE4]
    else $error("parity mask not stored");
  a_frame_timeout: assert property (@(posedge core_clk) disable iff (!nrst)
    reg_wr && reg_addr == uimsk_pkg::UIMSK_ENABLE_MASK_OFS
    |=> st_reg.mask[3:2] == $past(reg_wdata[7:6])) // [RULE5]
    else $error("framing or timeout mask wrong");
  a_tx_readback: assert property (@(posedge core_clk) disable iff (!nrst)
    s_mask_write(5) ##1 !reg_wr ##1 (reg_rd &&
      reg_addr == uimsk_pkg::UIMSK_ENABLE_MASK_OFS) |=> reg_rdata[5]) // [RULE6]
    else $error("transmit mask not read back");
  a_rx_block: assert property (@(posedge core_clk) disable iff (!nrst)
    !st_reg.mask[0] |=> !masked_irq[0]) // [RULE7]
    else $error("receive request passed while masked");
  a_rsvd_zero: assert property (@(posedge core_clk) disable iff (!nrst)
    reg_rdata[3:0] == 4'h0 && reg_rdata[31:11] == 21'h0) // [RULE8]
    else $error("reserved bits read nonzero");
  // A low reset sampled on one edge must leave the mask cleared on the next
  a_reset_mask: assert property (@(posedge core_clk)
    !nrst |=> st_reg.mask == uimsk_pkg::UIMSK_MASK_RESET) // [RULE2]
    else $error("mask not zero after reset");

  // Read strobe aimed at the mask register
  sequence s_mask_read;
    reg_rd && reg_addr == uimsk_pkg::UIMSK_ENABLE_MASK_OFS;
  endsequence

  // Read strobe aimed at the raw status register
  sequence s_raw_read;
    reg_rd && reg_addr == uimsk_pkg::UIMSK_RAW_STATUS_OFS;
  endsequence

  // Read strobe aimed at the masked status register
  sequence s_masked_read;
    reg_rd && reg_addr == uimsk_pkg::UIMSK_MASKED_STATUS_OFS;
  endsequence

  // Readback of the whole mask field, one cycle after the strobe
  a_mask_readback: assert property (@(posedge core_clk) disable iff (!nrst)
    s_mask_read |=> reg_rdata[10:4] == $past(st_reg.mask)) // [RULE2]
    else $error("mask field not read back");

  // Mask only moves on a write to its own offset
  a_mask_hold: assert property (@(posedge core_clk) disable iff (!nrst)
    !(reg_wr && reg_addr == uimsk_pkg::UIMSK_ENABLE_MASK_OFS)
    |=> st_reg.mask == $past(st_reg.mask)) // [RULE2]
    else $error("mask changed without a write");

  // Raw sources are visible ahead of masking
  a_raw_readback: assert property (@(posedge core_clk) disable iff (!nrst)
    s_raw_read |=> reg_rdata[10:4] == $past(raw_irq))
    else $error("raw status not read back");

  // Masked status shows the gate outputs of the read cycle
  a_masked_readback: assert property (@(posedge core_clk) disable iff (!nrst)
    s_masked_read |=> reg_rdata[10:4] == $past(gif.gated)) // [RULE1]
    else $error("masked status not read back");

  // Read data fall back to zero when no read was made
  a_idle_rdata: assert property (@(posedge core_clk) disable iff (!nrst)
    !reg_rd |=> reg_rdata == uimsk_pkg::UIMSK_RSVD_VALUE) // [RULE8]
    else $error("read data left standing");

  // Every output quiet on the edge after a reset edge
  a_reset_rdata: assert property (@(posedge core_clk)
    !nrst |=> reg_rdata == uimsk_pkg::UIMSK_RSVD_VALUE) // [RULE8]
    else $error("read data not zero after reset");
  a_reset_irq: assert property (@(posedge core_clk)
    !nrst |=> masked_irq == 7'h00 && !uart_irq && !event_irq) // [RULE1]
    else $error("requests not zero after reset");

  // Combined line is the OR of the masked sources one cycle on
  a_uart_or: assert property (@(posedge core_clk) disable iff (!nrst)
    $past(nrst) |-> uart_irq == |$past(raw_irq & st_reg.mask)) // [RULE1]
    else $error("combined request wrong");

  // Pass side: a set mask bit with its source high must reach the output
  a_overrun_pass: assert property (@(posedge core_clk) disable iff (!nrst)
    st_reg.mask[6] && raw_irq[6] |=> masked_irq[6]) // [RULE2]
    else $error("overrun request not forwarded");
  a_break_pass: assert property (@(posedge core_clk) disable iff (!nrst)
    st_reg.mask[5] && raw_irq[5] |=> masked_irq[5]) // [RULE3]
    else $error("break request not forwarded");
  a_parity_pass: assert property (@(posedge core_clk) disable iff (!nrst)
    st_reg.mask[4] && raw_irq[4] |=> masked_irq[4]) // [RULE4]
    else $error("parity request not forwarded");
  a_frame_pass: assert property (@(posedge core_clk) disable iff (!nrst)
    st_reg.mask[3] && raw_irq[3] |=> masked_irq[3]) // [RULE5]
    else $error("framing request not forwarded");
  a_timeout_pass: assert property (@(posedge core_clk) disable iff (!nrst)
    st_reg.mask[2] && raw_irq[2] |=> masked_irq[2]) // [RULE5]
    else $error("timeout request not forwarded");
  a_tx_pass: assert property (@(posedge core_clk) disable iff (!nrst)
    st_reg.mask[1] && raw_irq[1] |=> masked_irq[1]) // [RULE6]
    else $error("transmit request not forwarded");
  a_rx_pass: assert property (@(posedge core_clk) disable iff (!nrst)
    st_reg.mask[0] && raw_irq[0] |=> masked_irq[0]) // [RULE7]
    else $error("receive request not forwarded");

  // Block side: a clear mask bit keeps its output low whatever the source
  a_overrun_block: assert property (@(posedge core_clk) disable iff (!nrst)
    !st_reg.mask[6] |=> !masked_irq[6]) // [RULE2]
    else $error("overrun request passed while masked");
  a_break_block: assert property (@(posedge core_clk) disable iff (!nrst)
    !st_reg.mask[5] |=> !masked_irq[5]) // [RULE3]
    else $error("break request passed while masked");
  a_parity_block: assert property (@(posedge core_clk) disable iff (!nrst)
    !st_reg.mask[4] |=> !masked_irq[4]) // [RULE4]
    else $error("parity request passed while masked");
  a_frame_block: assert property (@(posedge core_clk) disable iff (!nrst)
    !st_reg.mask[3] |=> !masked_irq[3]) // [RULE5]
    else $error("framing request passed while masked");
  a_timeout_block: assert property (@(posedge core_clk) disable iff (!nrst)
    !st_reg.mask[2] |=> !masked_irq[2]) // [RULE5]
    else $error("timeout request passed while masked");
  a_tx_block: assert property (@(posedge core_clk) disable iff (!nrst)
    !st_reg.mask[1] |=> !masked_irq[1]) // [RULE6]
    else $error("transmit request passed while masked");

  // Write bits that land on reserved positions must never be stored
  a_rsvd_write: assert property (@(posedge core_clk) disable iff (!nrst)
    s_mask_read |=> reg_rdata[3:0] == 4'h0) // [RULE8]
    else $error("reserved mask bits not zero");

  // Event level follows status and event mask together
  a_evt_level: assert property (@(posedge core_clk) disable iff (!nrst)
    event_irq == |(st_reg.evt & st_reg.evt_mask))
    else $error("event line disagrees with status");

  // A rising request in the clearing cycle must keep its status bit
  a_evt_set_wins: assert property (@(posedge core_clk) disable iff (!nrst)
    reg_wr && reg_addr == uimsk_pkg::UIMSK_EVENT_STATUS_OFS &&
    reg_wdata[4] && gif.gated[0] && !st_reg.masked[0] |=> st_reg.evt[0])
    else $error("event clear beat a new request");

  // A write that sets the receive mask must show in the stored copy
  a_rx_mask: assert property (@(posedge core_clk) disable iff (!nrst)
    s_mask_write(4) |=> st_reg.mask[0]) // [RULE7]
    else $error("receive mask not stored");

  // A write that sets the transmit mask must show in the stored copy
  a_tx_mask: assert property (@(posedge core_clk) disable iff (!nrst)
    s_mask_write(5) |=> st_reg.mask[1]) // [RULE6]
    else $error("transmit mask not stored");

  // Writes elsewhere leave the mask untouched, so decode stays exact
  a_other_write: assert property (@(posedge core_clk) disable iff (!nrst)
    reg_wr && reg_addr != uimsk_pkg::UIMSK_ENABLE_MASK_OFS
    |=> st_reg.mask == $past(st_reg.mask)) // [RULE2]
    else $error("mask hit by a foreign write");
endmodule : uimsk_top
